/* logic/cpcs_regs.vh */
`ifndef CPCS_REGS_VH
`define CPCS_REGS_VH
// calibration request filter counts (sample clocks)
`define CPCS_CAL_LOW_MIN   16'h0050
`define CPCS_CAL_HIGH_MIN  16'h0050
// power-up calibration delays (sample clocks)
`define CPCS_DLY_SHORT     32'h0000_1000
`define CPCS_DLY_LONG      32'h0004_0000
// calibration phase lengths (sample clocks)
`define CPCS_TERM_CYCLES   16'h0040
`define CPCS_CONV_CYCLES   16'h0100
// delay select pin decode
`define CPCS_SEL_SHORT     2'h0
`define CPCS_SEL_LONG      2'h1
`define CPCS_SEL_FLOAT     2'h2
// data widths
`define CPCS_WORD_W        8
`endif

/* logic/cpcs_sequencer.v */
`timescale 1ns/1ps
`include "cpcs_regs.vh"

// How it works
// - calibrate after power-up and on every valid request seen when idle, same procedure except a request with trim disabled in extended mode skips the trim
// - calib_busy is high exactly while a calibration runs
// - forwarded clock stops during calibration unless trim_disable is set in extended mode
// - power-up calibration waits a delay after power applied
// - request pin high at power-up skips power-up calibration
// - request valid after low count then high count; starts after high count
// - on-command calibration trims termination unless trim-disable in extended mode
// - delay select picks one of two power-up delays
// - full power-down at power-up holds the delay counter at zero
// - extended mode ignores delay select for the delay, uses short delay; floating select still enables dual-edge
// - edge select high changes data on rising clock edge, else falling
// - dual-edge mode feeds one input to both converters, one per edge
// - dual-edge demux presents delayed q, delayed i, q, i in parallel
// - dual-edge without demux presents q then i on two buses
// - floating delay select enables dual-edge (on i, or on q if ext_des_q_input in extended mode) and short delay
// - full power-down stops all, q power-down stops q only
// - powered-down channel outputs go high impedance
// - full power-down waits for running calibration to finish
// - full power-down at power-up defers power-up calibration
// - request pin ignored while powered down
// - range from range_select normally, from adjust value in extended mode
module cpcs_sequencer #(
	parameter [31:0] DLY_SHORT = `CPCS_DLY_SHORT,
	parameter [31:0] DLY_LONG  = `CPCS_DLY_LONG
) (
	input  wire                     clk,
	input  wire                     reset,
	input  wire                     cal_request,
	input  wire [1:0]               calib_delay_select,
	input  wire                     full_powerdown,
	input  wire                     q_powerdown,
	input  wire                     clock_edge_select,
	input  wire                     range_select,
	input  wire                     extended_mode,
	input  wire                     trim_disable,
	input  wire                     ext_des_q_input,
	input  wire                     ext_range_value,
	input  wire                     demux_mode,
	input  wire                     sample_valid,
	input  wire [`CPCS_WORD_W-1:0]  conv_i_word,
	input  wire [`CPCS_WORD_W-1:0]  conv_q_word,
	output reg                      calib_busy,
	output reg                      term_trim_active,
	output reg                      clock_run,
	output reg                      data_edge_rising,
	output reg                      des_active,
	output reg                      des_use_q_input,
	output reg                      range_high,
	output reg                      dev_powered_down,
	output reg                      q_channel_off,
	output reg [`CPCS_WORD_W-1:0]   i_bus,
	output reg [`CPCS_WORD_W-1:0]   q_bus,
	output reg [`CPCS_WORD_W-1:0]   i_bus_delayed,
	output reg [`CPCS_WORD_W-1:0]   q_bus_delayed,
	output reg                      i_bus_oe,
	output reg                      q_bus_oe
);

	localparam [4:0] ST_WAIT = 5'h01;
	localparam [4:0] ST_IDLE = 5'h02;
	localparam [4:0] ST_TERM = 5'h04;
	localparam [4:0] ST_CONV = 5'h08;
	localparam [4:0] ST_OFF  = 5'h10;

	// ****************************************
	// input synchronisers
	// ****************************************
	reg       cal_s1_reg, cal_s2_reg;
	reg       pd_s1_reg, pd_s2_reg;
	reg       pdq_s1_reg, pdq_s2_reg;
	reg [1:0] dsel_s1_reg, dsel_s2_reg;

	always @(posedge clk) begin
		cal_s1_reg  <= cal_request;
		cal_s2_reg  <= cal_s1_reg;
		pd_s1_reg   <= full_powerdown;
		pd_s2_reg   <= pd_s1_reg;
		pdq_s1_reg  <= q_powerdown;
		pdq_s2_reg  <= pdq_s1_reg;
		dsel_s1_reg <= calib_delay_select;
		dsel_s2_reg <= dsel_s1_reg;
	end

	// ****************************************
	// functions
	// ****************************************
	function [15:0] sat_inc;
		input [15:0] v;
		begin
			sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
		end
	endfunction

	// last cycle of a counted span
	// shared by the power-up delay and both calibration phases,
	// so every span ends after exactly len counted cycles
	function at_end;
		input [31:0] cnt;
		input [31:0] len;
		begin
			at_end = (cnt + 32'h0000_0001 >= len);
		end
	endfunction

	// ****************************************
	// request filter
	// ****************************************
	reg [15:0] low_cnt_reg;
	reg [15:0] high_cnt_reg;
	reg        armed_reg;
	reg        req_pulse_reg;
	reg        first_reg;
	reg        skip_pwrup_reg;
	reg [4:0]  state_reg;
	wire       busy_now;
	wire       off_now;

	// calibration running in either phase
	assign busy_now = (state_reg == ST_TERM) || (state_reg == ST_CONV);
	// powered down, also while held at power-up
	// a device held down before its first calibration is just as dark
	// as one that entered power-down later, so both count here
	assign off_now  = (state_reg == ST_OFF) || ((state_reg == ST_WAIT) && pd_s2_reg);

	// low count arms, high count fires once
	always @(posedge clk) begin
		if (reset) begin
			low_cnt_reg   <= 16'h0000;
			high_cnt_reg  <= 16'h0000;
			armed_reg     <= 1'b0;
			req_pulse_reg <= 1'b0;
		end else begin
			req_pulse_reg <= 1'b0;
			// activity ignored while powered down
			// counts restart so a request half-seen before power-down
			// cannot complete once the device wakes up again
			if (off_now) begin
				low_cnt_reg  <= 16'h0000;
				high_cnt_reg <= 16'h0000;
				armed_reg    <= 1'b0;
			end else if (!cal_s2_reg) begin
				high_cnt_reg <= 16'h0000;
				low_cnt_reg  <= sat_inc(low_cnt_reg);
				if (sat_inc(low_cnt_reg) >= `CPCS_CAL_LOW_MIN)
					armed_reg <= 1'b1;
			end else begin
				low_cnt_reg  <= 16'h0000;
				high_cnt_reg <= sat_inc(high_cnt_reg);
				if (armed_reg && sat_inc(high_cnt_reg) == `CPCS_CAL_HIGH_MIN) begin
					req_pulse_reg <= 1'b1;
					armed_reg     <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// power-up delay selection
	// ****************************************
	reg        use_long;
	reg        des_mode;
	reg [31:0] dly_target;

	always @* begin
		des_mode   = extended_mode ? 1'b0 : (dsel_s2_reg == `CPCS_SEL_FLOAT);
		use_long   = !extended_mode && (dsel_s2_reg == `CPCS_SEL_LONG);
		dly_target = use_long ? DLY_LONG : DLY_SHORT;
	end

	// ****************************************
	// calibration sequencer
	// ****************************************
	reg [31:0] dly_cnt_reg;
	reg [15:0] ph_cnt_reg;

	// one procedure for power-up and requests
	always @(posedge clk) begin
		if (reset) begin
			state_reg      <= ST_WAIT;
			dly_cnt_reg    <= 32'h0000_0000;
			ph_cnt_reg     <= 16'h0000;
			first_reg      <= 1'b1;
			skip_pwrup_reg <= 1'b0;
		end else begin
			first_reg <= 1'b0;
			// request pin high at power-up skips
			if (first_reg && cal_s2_reg)
				skip_pwrup_reg <= 1'b1;
			case (state_reg)
				ST_WAIT: begin
					if (first_reg || pd_s2_reg) begin
						dly_cnt_reg <= 32'h0000_0000;
					end else if (skip_pwrup_reg) begin
						state_reg <= ST_IDLE;
					end else if (at_end(dly_cnt_reg, dly_target)) begin
						// delay elapsed, start
						// power-up calibration always trims the termination
						state_reg     <= ST_TERM;
						ph_cnt_reg    <= 16'h0000;
					end else begin
						dly_cnt_reg <= dly_cnt_reg + 32'h0000_0001;
					end
				end
				ST_IDLE: begin
					if (pd_s2_reg) begin
						state_reg <= ST_OFF;
					end else if (req_pulse_reg) begin
						state_reg     <= (extended_mode && trim_disable) ? ST_CONV : ST_TERM;
						ph_cnt_reg    <= 16'h0000;
					end
				end
				ST_TERM: begin
					if (at_end({16'h0000, ph_cnt_reg}, {16'h0000, `CPCS_TERM_CYCLES})) begin
						state_reg  <= ST_CONV;
						ph_cnt_reg <= 16'h0000;
					end else begin
						ph_cnt_reg <= ph_cnt_reg + 16'h0001;
					end
				end
				ST_CONV: begin
					// power-down only after completion
					// a power-down seen mid-run is only honoured here
					if (at_end({16'h0000, ph_cnt_reg}, {16'h0000, `CPCS_CONV_CYCLES})) begin
						state_reg  <= pd_s2_reg ? ST_OFF : ST_IDLE;
						ph_cnt_reg <= 16'h0000;
					end else begin
						ph_cnt_reg <= ph_cnt_reg + 16'h0001;
					end
				end
				ST_OFF: begin
					if (!pd_s2_reg)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_WAIT;
			endcase
		end
	end

	// ****************************************
	// data path and status outputs
	// ****************************************
	reg [`CPCS_WORD_W-1:0] i_prev_reg, q_prev_reg;
	reg                    phase_reg;

	// status mirrors, one register stage behind the sequencer
	always @(posedge clk) begin
		if (reset) begin
			calib_busy       <= 1'b0;
			term_trim_active <= 1'b0;
			clock_run        <= 1'b0;
			data_edge_rising <= 1'b0;
			des_active       <= 1'b0;
			des_use_q_input  <= 1'b0;
			range_high       <= 1'b0;
		end else begin
			calib_busy       <= busy_now;
			term_trim_active <= (state_reg == ST_TERM);
			clock_run        <= !off_now && (!busy_now || (extended_mode && trim_disable));
			data_edge_rising <= clock_edge_select;
			// dual-edge, one input to both converters
			// extended mode takes either input, chosen by ext_des_q_input
			des_active       <= des_mode || (extended_mode && (dsel_s2_reg == `CPCS_SEL_FLOAT));
			des_use_q_input  <= extended_mode && ext_des_q_input;
			range_high       <= extended_mode ? ext_range_value : range_select;
		end
	end

	// ****************************************
	// power state and bus enables
	// ****************************************
	// enables drop together with the power-down flags
	always @(posedge clk) begin
		if (reset) begin
			dev_powered_down <= 1'b0;
			q_channel_off    <= 1'b0;
			i_bus_oe         <= 1'b0;
			q_bus_oe         <= 1'b0;
		end else begin
			dev_powered_down <= off_now;
			q_channel_off    <= off_now || pdq_s2_reg;
			i_bus_oe         <= !off_now;
			q_bus_oe         <= !(off_now || pdq_s2_reg);
		end
	end

	// ****************************************
	// output buses
	// ****************************************
	// word pairs only advance while the device is awake;
	// the receiver must still flush what stood before power-down
	always @(posedge clk) begin
		if (reset) begin
			i_bus         <= {`CPCS_WORD_W{1'b0}};
			q_bus         <= {`CPCS_WORD_W{1'b0}};
			i_bus_delayed <= {`CPCS_WORD_W{1'b0}};
			q_bus_delayed <= {`CPCS_WORD_W{1'b0}};
			i_prev_reg    <= {`CPCS_WORD_W{1'b0}};
			q_prev_reg    <= {`CPCS_WORD_W{1'b0}};
			phase_reg     <= 1'b0;
		end else if (sample_valid && !off_now) begin
			phase_reg <= ~phase_reg;
			if (!demux_mode) begin
				// q then i on two buses
				q_bus <= conv_q_word;
				i_bus <= conv_i_word;
			end else if (phase_reg) begin
				// delayed q, delayed i, q, i
				q_bus_delayed <= q_prev_reg;
				i_bus_delayed <= i_prev_reg;
				q_bus         <= conv_q_word;
				i_bus         <= conv_i_word;
			end else begin
				// first word of a pair waits for its partner
				q_prev_reg <= conv_q_word;
				i_prev_reg <= conv_i_word;
			end
		end
	end

endmodule

/* verif/cpcs_sequencer_sva.sv */
`timescale 1ns/1ps
module cpcs_sequencer_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic calib_busy,
	input wire logic clock_run,
	input wire logic extended_mode,
	input wire logic trim_disable,
	input wire logic clock_edge_select,
	input wire logic data_edge_rising,
	input wire logic dev_powered_down,
	input wire logic q_channel_off,
	input wire logic i_bus_oe,
	input wire logic q_bus_oe
);
	logic [15:0] busy_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// length of the running calibration
	always @(posedge clk) begin
		busy_cnt <= (reset || !calib_busy) ? 16'h0000 : busy_cnt + 16'h0001;
	end
	// ****************************************
	// properties
	// ****************************************
	a_busy_len_ok: assert property ($fell(calib_busy) |-> busy_cnt == 16'h0140 || busy_cnt == 16'h0100)
		else $error("calibration length off");
	a_busy_bounded: assert property (calib_busy |-> busy_cnt < 16'h0141)
		else $error("calibration overruns");
	a_clock_stops: assert property (calib_busy && $past(calib_busy) && !extended_mode |-> !clock_run)
		else $error("clock runs in calibration");
	a_clock_keeps: assert property (calib_busy && extended_mode && trim_disable |-> clock_run)
		else $error("clock stopped without trim");
	a_edge_follows: assert property ($stable(clock_edge_select)[*4] |-> data_edge_rising == clock_edge_select)
		else $error("edge select not followed");
	a_pd_hiz: assert property (dev_powered_down |-> !i_bus_oe && !q_bus_oe)
		else $error("bus driven in power-down");
	a_q_off_hiz: assert property (q_channel_off |-> !q_bus_oe)
		else $error("q bus driven while off");
	a_pd_not_busy: assert property (dev_powered_down |-> !calib_busy)
		else $error("busy while powered down");
	a_start_awake: assert property ($rose(calib_busy) |-> $past(dev_powered_down) == 1'b0)
		else $error("calibration left power-down");
endmodule
bind cpcs_sequencer cpcs_sequencer_sva u_sva (.clk, .reset, .calib_busy, .clock_run, .extended_mode, .trim_disable,
	.clock_edge_select, .data_edge_rising, .dev_powered_down, .q_channel_off, .i_bus_oe, .q_bus_oe);

/* verif/cpcs_board.sv */
`timescale 1ns/1ps
module cpcs_board (
	input  wire logic clk,
	input  wire logic go,
	output logic      cal_request
);
	int n = 0;
	initial cal_request = 1'b0;
	// low 90 clocks then high 90
	always @(posedge clk) begin
		n <= (n != 0) ? ((n == 200) ? 0 : n + 1) : (go ? 1 : 0);
		cal_request <= (n > 90 && n <= 180);
	end
endmodule

/* verif/cpcs_sequencer_tb_top.sv */
`timescale 1ns/1ps
module cpcs_sequencer_tb_top;
	logic       clk, reset, cal_hold, go, board_req, full_powerdown, q_powerdown, clock_edge_select;
	logic       range_select, extended_mode, trim_disable, ext_des_q_input, ext_range_value, demux_mode;
	logic       sample_valid, calib_busy, term_trim_active, clock_run, data_edge_rising, des_active;
	logic       des_use_q_input, range_high, dev_powered_down, q_channel_off, i_bus_oe, q_bus_oe;
	logic [1:0] calib_delay_select;
	logic [7:0] conv_i_word, conv_q_word, i_bus, q_bus, i_bus_delayed, q_bus_delayed;
	wire        cal_request = cal_hold | board_req;
	int         error_cnt = 0, n_checks = 0, t;
	logic [7:0] m_i, m_q, m_id, m_qd, m_ip, m_qp;
	logic       m_ph, data_on;
	cpcs_sequencer #(.DLY_SHORT(32'h10), .DLY_LONG(32'h40)) dut (.clk, .reset, .cal_request, .calib_delay_select,
		.full_powerdown, .q_powerdown, .clock_edge_select, .range_select, .extended_mode, .trim_disable,
		.ext_des_q_input, .ext_range_value, .demux_mode, .sample_valid, .conv_i_word, .conv_q_word, .calib_busy,
		.term_trim_active, .clock_run, .data_edge_rising, .des_active, .des_use_q_input, .range_high,
		.dev_powered_down, .q_channel_off, .i_bus, .q_bus, .i_bus_delayed, .q_bus_delayed, .i_bus_oe, .q_bus_oe);
	cpcs_board board (.clk, .go, .cal_request(board_req));
	// ****************************************
	// clock, traffic, tasks
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		sample_valid <= 1'($urandom);
		conv_i_word <= 8'($urandom);
		conv_q_word <= 8'($urandom);
	end
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	// bus reference built from the pairing rules
	always @(posedge clk) begin
		if (reset) begin
			{m_i, m_q, m_id, m_qd, m_ip, m_qp, m_ph} <= 49'h0;
		end else if (sample_valid) begin
			m_ph <= ~m_ph;
			if (!demux_mode || m_ph) begin
				m_i <= conv_i_word;
				m_q <= conv_q_word;
			end
			if (demux_mode && m_ph) begin
				m_id <= m_ip;
				m_qd <= m_qp;
			end
			if (demux_mode && !m_ph) begin
				m_ip <= conv_i_word;
				m_qp <= conv_q_word;
			end
		end
	end
	always @(negedge clk) begin
		if (data_on === 1'b1) begin
			check("q_bus", q_bus, m_q);
			check("i_bus", i_bus, m_i);
			check("q_bus_delayed", q_bus_delayed, m_qd);
			check("i_bus_delayed", i_bus_delayed, m_id);
		end
	end
	task automatic wait_busy(int lim);
		t = 0;
		while (calib_busy !== 1'b1 && t < lim) begin
			@(negedge clk);
			t++;
		end
	endtask
	// model: length and clock state from the mode pins
	task automatic cal_len(logic pd_mid);
		logic [15:0] exp_len;
		exp_len = (extended_mode && trim_disable) ? 16'h0100 : 16'h0140;
		wait_busy(2000);
		check("busy_up", calib_busy, 1);
		check("term", term_trim_active, !(extended_mode && trim_disable));
		t = 1;
		@(posedge clk) full_powerdown <= full_powerdown | pd_mid;
		@(negedge clk);
		check("clock_run", clock_run, extended_mode && trim_disable);
		while (calib_busy === 1'b1 && t < 1000) begin
			t++;
			@(negedge clk);
		end
		check("busy_len", 16'(t), exp_len);
	endtask
	task automatic req;
		@(posedge clk) go <= 1'b1;
		@(posedge clk) go <= 1'b0;
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#(100 * 20000);
		error_cnt++;
		conclude;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'hfe8d826d));
		{reset, cal_hold} = 2'h3;
		data_on = 1'b0;
		{go, full_powerdown, q_powerdown, clock_edge_select, range_select, extended_mode} = 6'h00;
		{trim_disable, ext_des_q_input, ext_range_value, demux_mode, sample_valid} = 5'h00;
		{conv_i_word, conv_q_word, calib_delay_select} = 18'h00000;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		wait_busy(300);
		check("no_cal", calib_busy, 0);
		@(posedge clk) cal_hold <= 1'b0;
		req;
		cal_len(0);
		@(posedge clk) begin
			reset <= 1'b1;
			full_powerdown <= 1'b1;
		end
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		wait_busy(200);
		check("pd_hold", calib_busy, 0);
		check("pd_state", dev_powered_down, 1);
		check("pd_hiz", {i_bus_oe, q_bus_oe}, 0);
		req;
		wait_busy(300);
		check("pd_ignore", calib_busy, 0);
		@(posedge clk) full_powerdown <= 1'b0;
		wait_busy(16);
		check("dly_min", calib_busy, 0);
		cal_len(0);
		req;
		cal_len(1);
		repeat (5) @(negedge clk);
		check("pd_after", dev_powered_down, 1);
		@(posedge clk) full_powerdown <= 1'b0;
		repeat (500) @(posedge clk);
		{extended_mode, trim_disable} <= 2'h3;
		req;
		cal_len(0);
		@(posedge clk) q_powerdown <= 1'b1;
		repeat (5) @(negedge clk);
		check("q_off", {q_channel_off, q_bus_oe, i_bus_oe}, 3'h5);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk) {clock_edge_select, range_select, ext_range_value} <= 3'($urandom);
			extended_mode <= k[0];
			repeat (5) @(negedge clk);
			check("edge", data_edge_rising, clock_edge_select);
			check("range", range_high, k[0] ? ext_range_value : range_select);
		end
		@(posedge clk) {extended_mode, calib_delay_select} <= 3'h2;
		repeat (5) @(negedge clk);
		check("des", {des_active, des_use_q_input}, 2'h2);
		@(posedge clk) begin
			reset <= 1'b1;
			q_powerdown <= 1'b0;
		end
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		data_on <= 1'b1;
		repeat (100) @(posedge clk);
		demux_mode <= 1'b1;
		repeat (100) @(posedge clk);
		data_on <= 1'b0;
		@(negedge clk);
		conclude;
	end
endmodule
